/* File: design/watchdog_defs.svh */
// register offsets, field positions, reset values and timing counts of the watchdog
// assumes: included by the prescaler, the top module and the bench by bare name
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define WD_OFF_CONTROL     12'h000
`define WD_OFF_MODE        12'h004
`define WD_OFF_STATUS      12'h008

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define WD_CR_RESTART_BIT  0
`define WD_CR_KEY_LSB      24
`define WD_CR_KEY_MSB      31
`define WD_KEY_VALUE       8'ha5

// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define WD_MR_VALUE_LSB    0
`define WD_MR_VALUE_MSB    11
`define WD_MR_FIEN_BIT     12
`define WD_MR_RSTEN_BIT    13
`define WD_MR_RPROC_BIT    14
`define WD_MR_DIS_BIT      15
`define WD_MR_DELTA_LSB    16
`define WD_MR_DELTA_MSB    27
`define WD_MR_DBGHLT_BIT   28
`define WD_MR_IDLEHLT_BIT  29
`define WD_MR_RESET        32'h3fff_2fff

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define WD_SR_UNF_BIT      0
`define WD_SR_ERR_BIT      1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define WD_PRESCALE_DIV    128
`define WD_SLOW_DIV        8

`endif

/* File: design/watchdog_pkg.sv */
// types used by the watchdog top module
// assumes: compiled before every watchdog module
package watchdog_pkg;

  typedef struct packed {
    logic        idleHalt;
    logic        debugHalt;
    logic [11:0] restartWindowDelta;
    logic        timerDisable;
    logic        processorOnlyResetSelect;
    logic        faultResetEnable;
    logic        faultInterruptEnable;
    logic [11:0] counterReloadValue;
  } mode_s;

  typedef struct packed {
    logic windowErrorFlag;
    logic underflowFlag;
  } status_s;

  typedef enum logic [2:0] {
    APB_IDLE   = 3'b001,
    APB_SETUP  = 3'b010,
    APB_ACCESS = 3'b100
  } apb_phase_e;

endpackage : watchdog_pkg

/* File: design/watchdog_prescaler.sv */
// slow-tick and divide-by-128 prescaler of the watchdog
// assumes: clk is the only clock; slowTick is a one-cycle enable
`include "watchdog_defs.svh"
module watchdog_prescaler #(
  parameter int SLOW_DIV = `WD_SLOW_DIV,
  parameter int PRE_DIV  = `WD_PRESCALE_DIV
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clear,
  input  wire logic run,
  output logic      countTick
);
  // a divide of one still needs a one-bit counter
  localparam int SW = (SLOW_DIV > 1) ? $clog2(SLOW_DIV) : 1;
  localparam int PW = (PRE_DIV > 1) ? $clog2(PRE_DIV) : 1;

  logic [SW-1:0] slowCnt_q;
  logic [PW-1:0] preCnt_q;
  logic          slowTick;

  // slow clock modelled as an enable from clk
  always_ff @(posedge clk) begin
    if (!resetn) begin
      slowCnt_q <= '0;
    end else if (slowCnt_q == SW'(SLOW_DIV - 1)) begin
      slowCnt_q <= '0;
    end else begin
      slowCnt_q <= slowCnt_q + SW'(1);
    end
  end

  assign slowTick = (slowCnt_q == SW'(SLOW_DIV - 1));

  // halting freezes the divider too, so the period resumes intact
  always_ff @(posedge clk) begin
    if (!resetn || clear) begin
      preCnt_q <= '0;
    end else if (slowTick && run) begin
      preCnt_q <= preCnt_q + PW'(1);
    end
  end

  assign countTick = slowTick && run && (preCnt_q == PW'(PRE_DIV - 1));

endmodule : watchdog_prescaler

/* File: design/watchdog_counter.sv */
// 12-bit down counter with reload
// assumes: load and tick come from the same clk domain
module watchdog_counter #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  input  wire logic         tick,
  output logic [W-1:0]      count,
  output logic              underflow
);
  logic [W-1:0] count_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_q <= '1;
    end else if (load) begin
      count_q <= loadValue;
    end else if (tick && count_q != '0) begin
      count_q <= count_q - W'(1);
    end
  end

  assign count     = count_q;
  assign underflow = tick && !load && (count_q == '0);

endmodule : watchdog_counter

/* File: design/windowed_watchdog_timer.sv */
// windowed watchdog timer with APB register slave
// assumes: APB master on clk; resetn is the processor reset, synchronous
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`include "watchdog_defs.svh"
module windowed_watchdog_timer
  import watchdog_pkg::*;
#(
  parameter int CNT_W    = 12,
  parameter int SLOW_DIV = `WD_SLOW_DIV
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        debugState,
  input  wire logic        idleState,
  output logic             faultIrq,
  output logic             faultLine,
  output logic             systemResetReq,
  output logic             processorResetReq
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // only the second stage feeds logic; the first may be metastable
  logic [1:0] pinRaw;
  logic [1:0] pinSync;
  logic       dbgSynced;
  logic       idleSynced;

  assign pinRaw = {idleState, debugState};

  for (genvar i = 0; i < 2; i++) begin : gSync
    logic [1:0] stage_q;

    always_ff @(posedge clk) begin
      if (!resetn) begin
        stage_q <= 2'h0;
      end else begin
        stage_q <= {stage_q[0], pinRaw[i]};
      end
    end

    assign pinSync[i] = stage_q[1];
  end

  assign dbgSynced  = pinSync[0];
  assign idleSynced = pinSync[1];

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic  busAccess;
  logic  wrControl;
  logic  wrMode;
  logic  rdStatus;
  logic  mapped;
  logic  keyOk;
  logic  restartReq;

  assign busAccess = psel && penable && pready;
  assign mapped    = paddr == `WD_OFF_CONTROL || paddr == `WD_OFF_MODE ||
                     paddr == `WD_OFF_STATUS;
  assign wrControl = busAccess && pwrite && paddr == `WD_OFF_CONTROL;
  assign wrMode    = busAccess && pwrite && paddr == `WD_OFF_MODE;
  assign rdStatus  = busAccess && !pwrite && paddr == `WD_OFF_STATUS;
  assign keyOk     = pwdata[`WD_CR_KEY_MSB:`WD_CR_KEY_LSB] == `WD_KEY_VALUE;
  assign restartReq = wrControl && keyOk && pwdata[`WD_CR_RESTART_BIT];

  // ------------------------------------------------------------
  // mode register, write once
  // ------------------------------------------------------------
  // reset word is a full bus word; the top bits are unused
  localparam logic [31:0] MODE_RESET = `WD_MR_RESET;

  mode_s mode_q;
  logic  modeLocked_q;
  logic  modeAccept;

  assign modeAccept = wrMode && !modeLocked_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_q       <= mode_s'(MODE_RESET[$bits(mode_s)-1:0]);
      modeLocked_q <= 1'b0;
    end else if (modeAccept) begin
      mode_q       <= mode_s'(pwdata[$bits(mode_s)-1:0]);
      modeLocked_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // counter and prescaler
  // ------------------------------------------------------------
  logic             run;
  logic             countTick;
  logic             reload;
  logic [CNT_W-1:0] count;
  logic             underflow;
  logic             windowOk;

  // halting and disabling freeze both divider and counter
  assign run = !mode_q.timerDisable &&
               !(mode_q.debugHalt && dbgSynced) &&
               !(mode_q.idleHalt && idleSynced);
  // compared against the count as it stands on the write edge
  assign windowOk = count <= mode_q.restartWindowDelta;
  assign reload   = modeAccept || (restartReq && windowOk);

  watchdog_prescaler #(
    .SLOW_DIV (SLOW_DIV),
    .PRE_DIV  (`WD_PRESCALE_DIV)
  ) uPrescaler (
    .clk       (clk),
    .resetn    (resetn),
    .clear     (reload),
    .run       (run),
    .countTick (countTick)
  );

  watchdog_counter #(
    .W (CNT_W)
  ) uCounter (
    .clk       (clk),
    .resetn    (resetn),
    .load      (reload),
    .loadValue (modeAccept ? pwdata[`WD_MR_VALUE_MSB:`WD_MR_VALUE_LSB]
                           : mode_q.counterReloadValue),
    .tick      (countTick),
    .count     (count),
    .underflow (underflow)
  );

  // ------------------------------------------------------------
  // status flags and fault
  // ------------------------------------------------------------
  status_s status_q;
  logic    setUnf;
  logic    setErr;
  logic    faultSet;

  assign setUnf   = underflow;
  assign setErr   = restartReq && !windowOk;
  assign faultSet = (setUnf && mode_q.faultResetEnable) || setErr;

  // a new event in the read cycle survives the clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_q <= '0;
    end else begin
      status_q.underflowFlag   <= setUnf || (status_q.underflowFlag && !rdStatus);
      status_q.windowErrorFlag <= setErr || (status_q.windowErrorFlag && !rdStatus);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      faultLine <= 1'b0;
    end else begin
      faultLine <= faultSet || (faultLine && !rdStatus);
    end
  end

  // interrupt tracks the flags' next state so it clears with them
  always_ff @(posedge clk) begin
    if (!resetn) begin
      faultIrq <= 1'b0;
    end else begin
      faultIrq <= mode_q.faultInterruptEnable &&
                  (setUnf || setErr ||
                   ((status_q.underflowFlag || status_q.windowErrorFlag) && !rdStatus));
    end
  end

  // with reset enabled, request levels follow the fault line (system only if not processor-only); the controller resets us
  always_ff @(posedge clk) begin
    if (!resetn) begin
      systemResetReq    <= 1'b0;
      processorResetReq <= 1'b0;
    end else begin
      systemResetReq    <= mode_q.faultResetEnable &&
                           !mode_q.processorOnlyResetSelect &&
                           (faultSet || (faultLine && !rdStatus));
      processorResetReq <= mode_q.faultResetEnable &&
                           (faultSet || (faultLine && !rdStatus));
    end
  end

  // ------------------------------------------------------------
  // APB response
  // ------------------------------------------------------------
  // one wait state: pready is registered high in the second access cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= !mapped;
      if (!pwrite && paddr == `WD_OFF_MODE) begin
        prdata <= {2'h0, mode_q};
      end else if (!pwrite && paddr == `WD_OFF_STATUS) begin
        // an event landing on this edge is reported, not lost to the clear
        prdata <= {30'h0, status_q | {setErr, setUnf}};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_LOCK_HOLDS: assert property (
    modeLocked_q && wrMode |=> $stable(mode_q))
    else $error("mode changed after lock");
  AST_MODE_RELOAD: assert property (
    modeAccept |=> count == $past(pwdata[`WD_MR_VALUE_MSB:`WD_MR_VALUE_LSB]))
    else $error("mode write did not reload counter");
  AST_RESTART_RELOAD: assert property (
    restartReq && windowOk && !modeAccept |=> count == mode_q.counterReloadValue)
    else $error("restart did not reload");
  AST_BAD_KEY: assert property (
    wrControl && !keyOk |=> !status_q.windowErrorFlag || $past(status_q.windowErrorFlag))
    else $error("unkeyed write had effect");
  AST_UNF_FLAG: assert property (
    underflow |=> status_q.underflowFlag)
    else $error("underflow flag not set");
  AST_ERR_FAULT: assert property (
    setErr |=> faultLine && status_q.windowErrorFlag)
    else $error("window error not flagged");
  AST_IRQ: assert property (
    status_q.underflowFlag && mode_q.faultInterruptEnable && !rdStatus |=> faultIrq)
    else $error("interrupt missing");
  AST_READ_CLEAR: assert property (
    rdStatus && !faultSet |=> !faultLine)
    else $error("status read did not clear fault");
  AST_DISABLED: assert property (
    mode_q.timerDisable |-> !countTick)
    else $error("disabled timer ticked");
  AST_PROC_ONLY: assert property (
    processorResetReq && mode_q.processorOnlyResetSelect |-> !systemResetReq)
    else $error("system reset with processor-only select");
  AST_READY_ONE_WAIT: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
  AST_LOCK_SET: assert property (
    modeAccept |=> modeLocked_q)
    else $error("mode lock not set");
  AST_UNMAPPED: assert property (
    psel && penable && !pready && !mapped |=> pslverr)
    else $error("unmapped access not refused");
  AST_RESET_STATE: assert property (disable iff (1'b0)
    !resetn |=> mode_q == mode_s'(MODE_RESET[$bits(mode_s)-1:0]) && count == '1 &&
                !modeLocked_q && status_q == '0 && !faultLine)
    else $error("reset did not restore initial state");

  // ------------------------------------------------------------
  // assertions: counter and fault path
  // ------------------------------------------------------------
  AST_COUNT_STEP: assert property (
    !reload |=> count == $past(count) || count == $past(count) - CNT_W'(1))
    else $error("counter moved by more than one");
  AST_DISABLED_HOLD: assert property (
    mode_q.timerDisable && !reload |=> count == $past(count))
    else $error("disabled counter moved");
  AST_HALT: assert property (
    (mode_q.debugHalt && dbgSynced) || (mode_q.idleHalt && idleSynced) |-> !countTick)
    else $error("halted counter ticked");
  AST_WINDOW_ERR: assert property (
    restartReq && count > mode_q.restartWindowDelta |=> status_q.windowErrorFlag && faultLine)
    else $error("restart outside window accepted");
  AST_WIDE_WINDOW: assert property (
    restartReq && mode_q.restartWindowDelta >= mode_q.counterReloadValue &&
    count <= mode_q.counterReloadValue |-> !setErr)
    else $error("restart inside wide window flagged");
  AST_UNF_FAULT: assert property (
    underflow && mode_q.faultResetEnable |=> faultLine)
    else $error("underflow did not raise fault");
  AST_FAULT_HELD: assert property (
    faultLine && !rdStatus |=> faultLine)
    else $error("fault line dropped without read");
  AST_IRQ_MASKED: assert property (
    !mode_q.faultInterruptEnable |=> !faultIrq)
    else $error("interrupt raised while masked");
  AST_IRQ_CLEAR: assert property (
    rdStatus && !setUnf && !setErr |=> !faultIrq)
    else $error("status read did not clear interrupt");
  AST_SYS_REQ: assert property (
    mode_q.faultResetEnable && !mode_q.processorOnlyResetSelect |=>
    systemResetReq == faultLine)
    else $error("system reset request does not follow fault");
  AST_PROC_REQ: assert property (
    mode_q.faultResetEnable |=> processorResetReq == faultLine)
    else $error("processor reset request does not follow fault");
  AST_NO_REQ: assert property (
    !mode_q.faultResetEnable |=> !processorResetReq && !systemResetReq)
    else $error("reset requested with reset disabled");

  COV_UNDERFLOW: cover property (underflow);
  COV_WINDOW_ERR: cover property (setErr);
  COV_RESTART_OK: cover property (restartReq && windowOk);
  COV_READ_CLEAR: cover property (rdStatus && status_q.underflowFlag);
  COV_PROC_RESET: cover property (processorResetReq && mode_q.processorOnlyResetSelect);

endmodule : windowed_watchdog_timer

/* File: bench/reset_ctrl_model.sv */
// reset controller model on the far side of the watchdog fault outputs
// assumes: one clk domain; the bench ands wdResetn into the watchdog reset
module reset_ctrl_model (
  input  wire logic clk,
  input  wire logic armed,
  input  wire logic systemResetReq,
  input  wire logic processorResetReq,
  output logic      wdResetn
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] holdCnt_q = 3'h0;

  // ------------------------------------------------------------
  // reset pulse
  // ------------------------------------------------------------
  // disarmed by default so tests can watch a held fault line
  always_ff @(posedge clk) begin
    if (holdCnt_q != 3'h0)
      holdCnt_q <= holdCnt_q - 3'h1;
    else if (armed && (systemResetReq || processorResetReq))
      holdCnt_q <= 3'h4;
  end

  assign wdResetn = (holdCnt_q == 3'h0);
endmodule : reset_ctrl_model

/* File: bench/windowed_watchdog_timer_tb.sv */
// self-checking bench for the windowed watchdog timer over apb
// assumes: one apb wait state; SLOW_DIV of 1 so a count tick is 128 clk
`include "watchdog_defs.svh"
module windowed_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk        = 1'b0;
  logic        hostResetn = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic        debugState = 1'b0;
  logic        idleState  = 1'b0;
  logic        armed      = 1'b0;
  logic [31:0] rd;
  logic        re;
  wire  [31:0] prdata;
  wire         pready, pslverr, faultIrq, faultLine;
  wire         systemResetReq, processorResetReq, wdResetn, resetn;
  int          err_count   = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  assign resetn = hostResetn & wdResetn;
  always #20 clk = ~clk;

  windowed_watchdog_timer #(.SLOW_DIV(1)) uut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debugState(debugState), .idleState(idleState),
    .faultIrq(faultIrq), .faultLine(faultLine), .systemResetReq(systemResetReq),
    .processorResetReq(processorResetReq)
  );

  reset_ctrl_model rcModel (
    .clk(clk), .armed(armed), .systemResetReq(systemResetReq),
    .processorResetReq(processorResetReq), .wdResetn(wdResetn)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task wrap_up;
    $display("counts: %0d compared, %0d mismatched", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task chkWord(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chkWord

  task chkBit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chkBit

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task restart(input logic [7:0] k);
    xfer(1'b1, `WD_OFF_CONTROL, {k, 23'h000000, 1'b1});
  endtask : restart

  // sel 0 waits on faultIrq, 1 on processorResetReq
  task waitHigh(input logic sel, input int lim, output int n);
    n = 0;
    while (n < lim && (sel ? processorResetReq : faultIrq) !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask : waitHigh

  task doReset;
    @(posedge clk);
    hostResetn <= 1'b0;
    repeat (6) @(posedge clk);
    hostResetn <= 1'b1;
  endtask : doReset

  // f = {idle, debug, disable, proc-only, reset en, irq en}
  function automatic logic [31:0] mkMode(logic [11:0] v, logic [11:0] d, logic [5:0] f);
    return {2'b00, f[5:4], d, f[3:0], v};
  endfunction : mkMode

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up;
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    int n;
    doReset;
    xfer(1'b0, `WD_OFF_MODE, 32'h0);
    chkWord(rd, `WD_MR_RESET);
    xfer(1'b0, 12'h00c, 32'h0);
    chkBit(re, 1'b1);
    xfer(1'b1, `WD_OFF_MODE, mkMode(12'h002, 12'h002, 6'h01));
    xfer(1'b1, `WD_OFF_MODE, mkMode(12'h0ff, 12'h0ff, 6'h00));
    xfer(1'b0, `WD_OFF_MODE, 32'h0);
    chkWord(rd, mkMode(12'h002, 12'h002, 6'h01));
    waitHigh(1'b0, 600, n);
    chkBit(faultIrq, 1'b1);
    chkBit(faultLine, 1'b0);
    xfer(1'b0, `WD_OFF_STATUS, 32'h0);
    chkWord(rd, 32'h1 << `WD_SR_UNF_BIT);
    repeat (2) @(posedge clk);
    chkBit(faultIrq, 1'b0);
    $display("test write-once and underflow done");

    doReset;
    xfer(1'b1, `WD_OFF_MODE, mkMode(12'h100, 12'h010, 6'h02));
    restart(8'h5a);
    repeat (3) @(posedge clk);
    chkBit(faultLine, 1'b0);
    restart(`WD_KEY_VALUE);
    repeat (2) @(posedge clk);
    chkBit(faultLine, 1'b1);
    chkBit(systemResetReq, 1'b1);
    chkBit(processorResetReq, 1'b1);
    repeat (20) @(posedge clk);
    chkBit(faultLine, 1'b1);
    xfer(1'b0, `WD_OFF_STATUS, 32'h0);
    chkWord(rd, 32'h1 << `WD_SR_ERR_BIT);
    repeat (2) @(posedge clk);
    chkBit(faultLine, 1'b0);
    xfer(1'b0, `WD_OFF_STATUS, 32'h0);
    chkWord(rd, 32'h0);
    $display("test key and window error done");

    doReset;
    armed <= 1'b1;
    xfer(1'b1, `WD_OFF_MODE, mkMode(12'h001, 12'h001, 6'h06));
    repeat (100) @(posedge clk);
    restart(`WD_KEY_VALUE);
    chkBit(faultLine, 1'b0);
    waitHigh(1'b1, 400, n);
    // two ticks from a cleared prescaler
    chkBit(n >= 250 && n <= 262, 1'b1);
    chkBit(systemResetReq, 1'b0);
    repeat (10) @(posedge clk);
    armed <= 1'b0;
    chkBit(faultLine, 1'b0);
    xfer(1'b0, `WD_OFF_MODE, 32'h0);
    chkWord(rd, `WD_MR_RESET);
    $display("test prescaler and fault reset done");

    doReset;
    xfer(1'b1, `WD_OFF_MODE, mkMode(12'h010, 12'h000, 6'h0b));
    repeat (2500) @(posedge clk);
    chkBit(faultLine, 1'b0);
    restart(`WD_KEY_VALUE);
    repeat (2) @(posedge clk);
    chkBit(faultLine, 1'b1);
    chkBit(faultIrq, 1'b1);
    $display("test disable done");

    debugState <= 1'b1;
    doReset;
    chkBit(faultLine, 1'b0);
    xfer(1'b1, `WD_OFF_MODE, mkMode(12'h001, 12'h001, 6'h31));
    repeat (400) @(posedge clk);
    chkBit(faultIrq, 1'b0);
    debugState <= 1'b0;
    idleState  <= 1'b1;
    repeat (400) @(posedge clk);
    chkBit(faultIrq, 1'b0);
    idleState  <= 1'b0;
    waitHigh(1'b0, 600, n);
    chkBit(faultIrq, 1'b1);
    $display("test halt done");
    wrap_up;
  end
endmodule : windowed_watchdog_timer_tb
